/* File: logic/dme_expander.sv */
// Contract
// - Frame table is read as 32-bit entries, each a vertical run of lines.
// - Line tables are read as 16-bit entries, each a horizontal pixel run.
// - The table base input carries the upper 16 physical address bits.
// - With fetch disabled: no table DMA, all-zero mode identifiers per pixel.
// - Run-last-line is the final line of the run, zero is the first line.
// - At line table end: replay unless line equals run-last-line, then step.
// - Line table address is base plus 512 times block plus 2 times offset.
// - Several frame entries may point at the same line table.
// - Run-last-pixel is the final pixel of a run; on a match step entry.
// - The window index selects one of 32 window entries giving mode bits.
// - The window table is 32 entries of 13 bits on chip.
// - Line tables are loaded into a 16x128 local RAM, 8 entries per word.
// - Line RAM reads take two clocks, so the next word is prefetched.
// - The frame table is held in a 16x128 local RAM.
// - Tables are fetched by DMA and expanded into a per-pixel mode stream.
// - Every DMA read address is 256-bit aligned, low five bits zero.
// - Request count is in 256-bit words; data returns in request order.
//
// Purpose: Expands run-length coded mode tables into a per-pixel mode stream.
// Assumes: Frame strobe and DMA port come from logic on core_clk.
// Notes:   Line tables are fetched 256 bytes from the 32-byte aligned start.
`timescale 1ns/1ps
`default_nettype none
`include "dme_params.svh"
module dme_expander
  import dme_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          fetch_enable,
  input  wire logic [15:0]   table_base,
  input  wire logic          frame_start,
  input  wire logic [10:0]   frame_last_line,
  input  wire logic [10:0]   line_last_pix,
  input  wire logic          win_wr_en,
  input  wire logic [4:0]    win_wr_index,
  input  wire logic [12:0]   win_wr_bits,
  output logic               dma_req_valid,
  output logic [31:0]        dma_req_addr,
  output logic [4:0]         dma_req_count,
  input  wire logic          dma_req_ready,
  input  wire logic          dma_data_valid,
  input  wire logic [127:0]  dma_data,
  output logic               mode_valid,
  output dme_mode_type       mode_out,
  input  wire logic          mode_ready
);
  dme_state_type q;
  dme_state_type d;
  logic          push;
  dme_mode_type  push_mode;
  logic          pop;
  logic [31:0]   fent;
  logic [15:0]   lent;
  logic          line_end;
  logic          run_go;

  // Start a line: read the first word of the line table out of the line RAM
  function automatic dme_state_type start_line(input dme_state_type s);
    dme_state_type r;
    r          = s;
    r.st       = DME_PRIME;
    r.rd_addr  = {3'h0, s.offset[`DME_OFF_WORD]};
    r.rd_v0    = 1'b1;
    r.epoch    = ~s.epoch;
    r.t0       = ~s.epoch;
    r.ent      = s.offset[`DME_OFF_ENT];
    r.have_cur = 1'b0;
    r.nxt_v    = 1'b0;
    r.pix      = '0;
    return r;
  endfunction

  // ***************************************
  // Next-state logic
  // ***************************************
  always_comb
  begin
    d         = q;
    push      = 1'b0;
    push_mode = '0;
    pop       = q.head_v & mode_ready;
    d.rd_v0   = 1'b0;
    // Frame entry and current line entry picked out of the stored words
    fent      = q.frame_ram[q.fe[5:2]][{~q.fe[1:0], 5'h00} +: 32];
    lent      = q.cur[{~q.ent, 4'h0} +: 16];
    line_end  = (q.pix == line_last_pix);
    run_go    = ~q.tail_v & (q.nxt_v | (q.ent != `DME_LAST_ENTRY) |
                             (q.pix != lent[`DME_LE_XEND]) | line_end);

    // Two-clock registered read of the line RAM
    d.s1 = q.line_ram[q.rd_addr];
    d.v1 = q.rd_v0;
    d.t1 = q.t0;
    d.s2 = q.s1;
    d.v2 = q.v1;
    d.t2 = q.t1;
    if (q.v2 && q.t2 == q.epoch)
    begin
      if (q.st == DME_PRIME && !q.have_cur)
      begin
        d.cur      = q.s2;
        d.have_cur = 1'b1;
        d.rd_addr  = q.rd_addr + `DME_ONE_WORD;
        d.rd_v0    = 1'b1;
        d.t0       = q.epoch;
      end
      else
      begin
        d.nxt   = q.s2;
        d.nxt_v = 1'b1;
        if (q.st == DME_PRIME)
          d.st = DME_RUN;
      end
    end

    // Request stands until the memory side takes it
    if (q.req.valid && dma_req_ready)
      d.req.valid = 1'b0;

    // Window table writes
    if (win_wr_en)
      d.win[win_wr_index] = win_wr_bits;

    unique case (q.st)
      DME_IDLE:
      begin
      end
      DME_FT_DATA:
      begin
        // Returned beats land in order of the request
        if (dma_data_valid)
        begin
          d.frame_ram[q.beat] = dma_data;
          d.beat              = q.beat + `DME_ONE_WORD;
          if (q.beat == `DME_LAST_BEAT)
            d.st = DME_FE_LOAD;
        end
      end
      DME_FE_LOAD:
      begin
        d.yend        = fent[`DME_FE_YEND];
        d.block       = fent[`DME_FE_BLOCK];
        d.offset      = fent[`DME_FE_OFFSET];
        d.req.valid   = 1'b1;
        // Base + 512*block + 2*offset, cut down to the 32-byte word below it
        d.req.addr    = {table_base, fent[`DME_FE_BLOCK],
                         fent[`DME_FE_OFF_HI], `DME_ALIGN_PAD};
        d.req.count   = `DME_LT_WORDS;
        d.beat        = '0;
        d.st          = DME_LT_DATA;
      end
      DME_LT_DATA:
      begin
        if (dma_data_valid)
        begin
          d.line_ram[q.beat] = dma_data;
          d.beat             = q.beat + `DME_ONE_WORD;
          if (q.beat == `DME_LAST_BEAT)
            d = start_line(d);
        end
      end
      DME_PRIME:
      begin
      end
      DME_RUN:
      begin
        if (run_go)
        begin
          push            = 1'b1;
          push_mode.index = lent[`DME_LE_INDEX];
          push_mode.bits  = q.win[lent[`DME_LE_INDEX]];
          if (q.pix == lent[`DME_LE_XEND] && !line_end)
          begin
            d.ent = q.ent + 3'h1;
            if (q.ent == `DME_LAST_ENTRY)
            begin
              d.cur     = q.nxt;
              d.nxt_v   = 1'b0;
              d.rd_addr = q.rd_addr + `DME_ONE_WORD;
              d.rd_v0   = 1'b1;
              d.t0      = q.epoch;
            end
          end
          d.pix = q.pix + `DME_ONE_PIX;
          if (line_end)
          begin
            d.pix = '0;
            if (q.line == frame_last_line)
              d.st = DME_IDLE;
            else if (q.line == q.yend)
            begin
              d.line = q.line + `DME_ONE_PIX;
              d.fe   = q.fe + `DME_ONE_FE;
              d.st   = DME_FE_LOAD;
            end
            else
            begin
              d      = start_line(d);
              d.line = q.line + `DME_ONE_PIX;
            end
          end
        end
      end
      DME_ZERO:
      begin
        // Fetch off: count pixels and emit zero modes only
        if (!q.tail_v)
        begin
          push  = 1'b1;
          d.pix = q.pix + `DME_ONE_PIX;
          if (line_end)
          begin
            d.pix  = '0;
            d.line = q.line + `DME_ONE_PIX;
            if (q.line == frame_last_line)
              d.st = DME_IDLE;
          end
        end
      end
    endcase

    // Disable drops any table activity at once
    if (!fetch_enable && q.st != DME_IDLE && q.st != DME_ZERO)
    begin
      d.st        = DME_ZERO;
      d.req.valid = 1'b0;
      d.rd_v0     = 1'b0;
      push        = 1'b0;
      // The pixel not pushed this cycle is emitted as zero, so keep position
      d.pix       = q.pix;
      d.line      = q.line;
    end

    // Frame start returns to the first entry and, with fetch enabled, reloads the frame table
    if (frame_start)
    begin
      d.line      = '0;
      d.pix       = '0;
      d.fe        = '0;
      d.beat      = '0;
      d.rd_v0     = 1'b0;
      d.epoch     = ~q.epoch;
      d.req.valid = fetch_enable;
      d.req.addr  = {table_base, `DME_BASE_PAD};
      d.req.count = `DME_FT_WORDS;
      d.st        = fetch_enable ? DME_FT_DATA : DME_ZERO;
      push        = 1'b0;
    end

    // Two-entry output buffer; producer stalls while the second entry is full
    if (pop)
    begin
      if (q.tail_v)
      begin
        d.head   = q.tail;
        d.tail_v = push;
        d.tail   = push_mode;
      end
      else
      begin
        d.head_v = push;
        d.head   = push_mode;
      end
    end
    else if (push)
    begin
      if (q.head_v)
      begin
        d.tail_v = 1'b1;
        d.tail   = push_mode;
      end
      else
      begin
        d.head_v = 1'b1;
        d.head   = push_mode;
      end
    end
  end

  // ***************************************
  // State register
  // ***************************************
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      q    <= '0;
      q.st <= DME_IDLE;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign dma_req_valid = q.req.valid;
  assign dma_req_addr  = q.req.addr;
  assign dma_req_count = q.req.count;
  assign mode_valid    = q.head_v;
  assign mode_out      = q.head;
endmodule
`default_nettype wire

/* File: logic/dme_params.svh */
// Purpose: Constants of the display-mode run expander.
// Assumes: Included by the design module only; the package does not include it.
// Notes:   Field ranges are written as part-select ranges.
`ifndef DME_PARAMS_SVH
`define DME_PARAMS_SVH
// Frame entry fields (32-bit entry)
`define DME_FE_YEND      26:16
`define DME_FE_BLOCK     14:8
`define DME_FE_OFFSET    7:0
`define DME_FE_OFF_HI    7:4
`define DME_OFF_WORD     3
`define DME_OFF_ENT      2:0
// Line entry fields (16-bit entry)
`define DME_LE_XEND      15:5
`define DME_LE_INDEX     4:0
// DMA transfer lengths in 256-bit words, and last 128-bit beat index
`define DME_FT_WORDS     5'h08
`define DME_LT_WORDS     5'h08
`define DME_LAST_BEAT    4'hF
// Address padding below the 64 KB base and the 256-bit alignment
`define DME_BASE_PAD     16'h0000
`define DME_ALIGN_PAD    5'h00
`define DME_LAST_ENTRY   3'h7
`define DME_ONE_PIX      11'h001
`define DME_ONE_FE       6'h01
`define DME_ONE_WORD     4'h1
`endif

/* File: logic/dme_pkg.sv */
// Purpose: Types of the display-mode run expander.
// Assumes: dme_params.svh supplies the numeric constants.
// Notes:   All block state lives in one packed struct.
`default_nettype none
package dme_pkg;
  // ***************************************
  // Stream and request carriers
  // ***************************************
  typedef struct packed {
    logic [4:0]  index;
    logic [12:0] bits;
  } dme_mode_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [4:0]  count;
  } dme_dma_req_type;

  // ***************************************
  // Sequencer states
  // ***************************************
  typedef enum logic [2:0] {
    DME_IDLE, DME_FT_DATA, DME_FE_LOAD, DME_LT_DATA, DME_PRIME, DME_RUN, DME_ZERO
  } dme_fsm_type;

  typedef struct packed {
    dme_fsm_type        st;
    logic [15:0][127:0] frame_ram;
    logic [15:0][127:0] line_ram;
    logic [31:0][12:0]  win;
    logic [3:0]         beat;
    logic [5:0]         fe;
    logic [10:0]        yend;
    logic [6:0]         block;
    logic [7:0]         offset;
    logic [10:0]        line;
    logic [10:0]        pix;
    logic [3:0]         rd_addr;
    logic               rd_v0;
    logic               t0;
    logic               v1;
    logic               t1;
    logic [127:0]       s1;
    logic               v2;
    logic               t2;
    logic [127:0]       s2;
    logic               epoch;
    logic               have_cur;
    logic [127:0]       cur;
    logic [127:0]       nxt;
    logic               nxt_v;
    logic [2:0]         ent;
    dme_dma_req_type    req;
    logic               head_v;
    dme_mode_type       head;
    logic               tail_v;
    dme_mode_type       tail;
  } dme_state_type;
endpackage
`default_nettype wire

/* File: tb/dme_expander_sva.sv */
// Purpose: Port checks for the display mode run expander.
// Assumes: One clock domain, core_clk, with reset active high.
// Notes:   Bound to every dme_expander instance.
`timescale 1ns/1ps
`default_nettype none
module dme_expander_sva
  import dme_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         reset,
  input wire logic         fetch_enable,
  input wire logic [15:0]  table_base,
  input wire logic         frame_start,
  input wire logic         dma_req_valid,
  input wire logic [31:0]  dma_req_addr,
  input wire logic [4:0]   dma_req_count,
  input wire logic         dma_req_ready,
  input wire logic         dma_data_valid,
  input wire logic         mode_valid,
  input wire dme_mode_type mode_out,
  input wire logic         mode_ready
);
  // ****************************************
  // Helper counters
  // ****************************************
  logic [4:0] pend_q;
  logic [2:0] dis_q;
  // Beats still owed, and settled cycles of draining while disabled
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pend_q <= 5'h00;
      dis_q  <= 3'h0;
    end
    else
    begin
      if (dma_req_valid && dma_req_ready)
        pend_q <= 5'h10;
      else if (dma_data_valid && pend_q != 5'h00)
        pend_q <= pend_q - 5'h01;
      if (fetch_enable || !mode_ready)
        dis_q <= 3'h0;
      else if (dis_q != 3'h6)
        dis_q <= dis_q + 3'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // Assertions
  // ****************************************
  addr_align_a: assert property (dma_req_valid |-> dma_req_addr[4:0] == 5'h00)
    else $error("table request address not aligned");
  word_count_a: assert property (dma_req_valid |-> dma_req_count == 5'h08)
    else $error("table request count wrong");
  base_bits_a: assert property (dma_req_valid |-> dma_req_addr[31:16] == table_base)
    else $error("table request outside base region");
  one_pending_a: assert property (dma_req_valid && dma_req_ready |-> pend_q == 5'h00)
    else $error("second table request before all beats returned");
  req_hold_a: assert property (dma_req_valid && !dma_req_ready && fetch_enable && !frame_start
    |=> dma_req_valid && $stable(dma_req_addr))
    else $error("table request dropped before taken");
  no_dma_off_a: assert property (!fetch_enable && !$past(fetch_enable) |-> !dma_req_valid)
    else $error("table request while fetch disabled");
  zero_mode_a: assert property (dis_q == 3'h6 && mode_valid |-> mode_out == '0)
    else $error("nonzero mode while fetch disabled");
  mode_hold_a: assert property (mode_valid && !mode_ready && fetch_enable && !frame_start
    |=> mode_valid && $stable(mode_out))
    else $error("mode changed while stalled");
  frame_restart_a: assert property (frame_start && fetch_enable
    |=> dma_req_valid && dma_req_addr[15:0] == 16'h0000)
    else $error("frame did not restart at first frame entry");
  req_taken_c: cover property (dma_req_valid && dma_req_ready);
  mode_stall_c: cover property (mode_valid && !mode_ready && fetch_enable);
  zero_out_c: cover property (dis_q == 3'h6 && mode_valid);
endmodule
bind dme_expander dme_expander_sva u_sva (
  .core_clk(core_clk), .reset(reset), .fetch_enable(fetch_enable), .table_base(table_base),
  .frame_start(frame_start), .dma_req_valid(dma_req_valid), .dma_req_addr(dma_req_addr),
  .dma_req_count(dma_req_count), .dma_req_ready(dma_req_ready),
  .dma_data_valid(dma_data_valid), .mode_valid(mode_valid), .mode_out(mode_out),
  .mode_ready(mode_ready)
);
`default_nettype wire

/* File: tb/dme_expander_test.sv */
// Purpose: Self-checking bench for the display mode run expander.
// Assumes: dme_mem_model answers the table fetches.
// Notes:   Two enabled frames, one cut mid-line, then one disabled frame.
`timescale 1ns/1ps
`default_nettype none
module dme_expander_test;
  import dme_pkg::*;
  logic         core_clk = 1'b0, reset = 1'b1, fetch_enable = 1'b0, frame_start = 1'b0;
  logic         win_wr_en = 1'b0, mode_ready = 1'b1, slow = 1'b0, stall = 1'b0;
  logic [15:0]  table_base = 16'h0000;
  logic [10:0]  last_line = 11'h003, last_pix = 11'h013;
  logic [4:0]   win_idx = 5'h00;
  logic [1:0]   cnt_q = 2'h0;
  logic [12:0]  win_bits = 13'h0000;
  logic [12:0]  wexp [32];
  logic         req_v, req_r, dat_v, mode_v;
  logic [31:0]  req_a;
  logic [4:0]   req_c;
  logic [127:0] dat;
  dme_mode_type mode;
  logic [31:0]  reqs [$];
  int           err_total = 0, tests_run = 0;
  dme_expander u_dut (.core_clk(core_clk), .reset(reset), .fetch_enable(fetch_enable),
    .table_base(table_base), .frame_start(frame_start), .frame_last_line(last_line),
    .line_last_pix(last_pix), .win_wr_en(win_wr_en), .win_wr_index(win_idx),
    .win_wr_bits(win_bits), .dma_req_valid(req_v), .dma_req_addr(req_a),
    .dma_req_count(req_c), .dma_req_ready(req_r), .dma_data_valid(dat_v), .dma_data(dat),
    .mode_valid(mode_v), .mode_out(mode), .mode_ready(mode_ready));
  dme_mem_model u_mem (.core_clk(core_clk), .reset(reset), .slow(slow), .dma_req_valid(req_v),
    .dma_req_addr(req_a), .dma_req_count(req_c), .dma_req_ready(req_r),
    .dma_data_valid(dat_v), .dma_data(dat));
  always #50 core_clk = ~core_clk;
  // Consumer stall pattern and request log
  always @(posedge core_clk)
  begin
    cnt_q <= cnt_q + 2'h1;
    mode_ready <= !stall || cnt_q != 2'h0;
    if (req_v === 1'b1 && req_r === 1'b1)
      reqs.push_back(req_a);
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_mode(input dme_mode_type g, input dme_mode_type e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_win(input logic [4:0] i, input logic [12:0] v);
    @(posedge core_clk);
    win_wr_en <= 1'b1;
    win_idx <= i;
    win_bits <= v;
    @(posedge core_clk);
    win_wr_en <= 1'b0;
    wexp[i] = v;
  endtask
  // Expected mode: lines 0-1 use table A, lines 2-3 table B entered at entry offset 4
  function automatic dme_mode_type exp_mode(input int y, input int x);
    logic [4:0] i;
    if (y < 2)
      i = (x == 0) ? 5'h01 : (x <= 9) ? 5'h02 : 5'h1F;
    else
      i = (x <= 4) ? 5'h05 : 5'h00;
    return '{i, wexp[i]};
  endfunction
  task automatic take(output dme_mode_type m);
    int k;
    for (k = 0; k < 400; k++)
    begin
      @(posedge core_clk);
      if (mode_v === 1'b1 && mode_ready === 1'b1)
        break;
    end
    m = mode;
    cmp_val(32'(k < 400), 32'h1);
  endtask
  task automatic start(input logic [15:0] base, input logic en, input logic slw);
    reqs.delete();
    @(posedge core_clk);
    table_base <= base;
    fetch_enable <= en;
    slow <= slw;
    stall <= slw;
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
  endtask
  task automatic t_frame(input logic [15:0] base, input logic slw);
    dme_mode_type g;
    start(base, 1'b1, slw);
    for (int y = 0; y < 4; y++)
      for (int x = 0; x < 20; x++)
      begin
        take(g);
        cmp_mode(g, exp_mode(y, x));
      end
    cmp_val(reqs.size(), 32'h3);
    cmp_val(reqs[0], {base, 16'h0000});
    cmp_val(reqs[1], {base, 16'h0200});
    cmp_val(reqs[2], {base, 16'h0400});
    $display("t_frame base %h done", base);
  endtask
  // Fetch dropped mid-line after pixel 24: position kept, buffered pixel 25 from the table, zero modes from pixel 26 on
  task automatic t_cut();
    dme_mode_type g;
    dme_mode_type z;
    z = '0;
    start(16'h0012, 1'b1, 1'b0);
    for (int p = 0; p < 80; p++)
    begin
      take(g);
      if (p == 24)
        fetch_enable <= 1'b0;
      cmp_mode(g, (p < 26) ? exp_mode(p / 20, p % 20) : z);
    end
    repeat (4) @(posedge core_clk);
    cmp_val(32'(mode_v), 32'h0);
    cmp_val(reqs.size(), 32'h2);
    $display("t_cut done");
  endtask
  task automatic t_off();
    dme_mode_type g;
    start(16'h0055, 1'b0, 1'b0);
    repeat (24)
    begin
      take(g);
      cmp_mode(g, '0);
    end
    cmp_val(reqs.size(), 32'h0);
    $display("t_off done");
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    u_mem.mem[0] = {32'h00010100, 32'h00030204, 64'h0};
    u_mem.mem[32] = {16'h0001, 16'h0122, 16'hFFFF, 80'h0};
    u_mem.mem[64] = {64'h0, 16'h0085, 16'hFFE0, 32'h0};
    for (int i = 0; i < 32; i++)
      wr_win(5'(i), 13'(i) * 13'h0123 + 13'h0007);
    t_frame(16'h0012, 1'b0);
    wr_win(5'h02, 13'h1ABC);
    t_frame(16'hABCD, 1'b1);
    t_cut();
    t_off();
    stop_test();
  end
  // Watchdog for a hung transfer
  initial
  begin
    #2000000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire

/* File: tb/dme_mem_model.sv */
// Purpose: Memory controller model answering table reads.
// Assumes: One request at a time; slow adds latency and beat gaps.
// Notes:   Holds only the 64 KB table region.
`timescale 1ns/1ps
`default_nettype none
module dme_mem_model
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         slow,
  input  wire logic         dma_req_valid,
  input  wire logic [31:0]  dma_req_addr,
  input  wire logic [4:0]   dma_req_count,
  output var  logic         dma_req_ready,
  output var  logic         dma_data_valid,
  output var  logic [127:0] dma_data
);
  logic [127:0] mem [4096];
  logic [11:0]  a;
  int           n;
  // Take a request, then return its beats in order
  initial
  begin
    for (n = 0; n < 4096; n++)
      mem[n] = 128'h0;
    dma_req_ready = 1'b0;
    dma_data_valid = 1'b0;
    dma_data = 128'h0;
    forever
    begin
      @(posedge core_clk);
      if (dma_req_valid === 1'b1 && !reset)
      begin
        repeat (slow ? 3 : 0) @(posedge core_clk);
        dma_req_ready <= 1'b1;
        @(posedge core_clk);
        a = dma_req_addr[15:4];
        n = 2 * dma_req_count;
        dma_req_ready <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
          dma_data_valid <= 1'b1;
          dma_data <= mem[a + 12'(i)];
          @(posedge core_clk);
          if (slow || i == n - 1)
          begin
            dma_data_valid <= 1'b0;
            dma_data <= ~mem[a + 12'(i)];
            if (slow)
              @(posedge core_clk);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire
